// ==== hw/rx_gain_index_control.sv ====
// Receive gain index pointers for two receivers under manual control.
// Assumes clk is the filter input clock; detector flags arrive on clk.
`timescale 1ns/1ps
`default_nettype none
`include "rx_gain_cfg.svh"

module rx_gain_index_control #(
    parameter int PW = 16
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [9:0]              reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic [7:0]              reg_wdata,
    output logic      [7:0]              reg_rdata,
    input  wire logic                    split_mode,
    input  wire logic                    digital_gain_en,
    input  wire logic                    pin_control_en,
    input  wire logic [6:0]              max_gain_index_limit,
    input  wire logic [6:0]              initial_fe_limit,
    input  wire logic                    rx1_gain_up_pin,
    input  wire logic                    rx1_gain_down_pin,
    input  wire logic                    rx2_gain_up_pin,
    input  wire logic                    rx2_gain_down_pin,
    input  wire rx_gain_pkg::ovl_flags_t rx1_flags,
    input  wire rx_gain_pkg::ovl_flags_t rx2_flags,
    input  wire logic                    ctrl_out_en,
    output logic      [7:0]              ctrl_out,
    output rx_gain_pkg::gain_idx_t       rx1_index,
    output rx_gain_pkg::gain_idx_t       rx2_index,
    input  wire logic [3:0]              power_meas_duration,
    input  wire logic                    samp_valid,
    input  wire logic [PW-1:0]           samp_power,
    output logic      [PW-1:0]           avg_power,
    output logic                         avg_valid
);

    initial begin
        if (PW < 1 || PW > 32) begin
            $error("rx_gain_index_control: PW out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step helpers

    function automatic logic [6:0] step_up(input logic [6:0] idx,
                                           input logic [3:0] inc,
                                           input logic [6:0] cap);
        logic [7:0] sum;
        sum = {1'b0, idx} + {4'h0, inc};
        step_up = (sum > {1'b0, cap}) ? cap : sum[6:0];
    endfunction

    function automatic logic [6:0] step_dn(input logic [6:0] idx,
                                           input logic [3:0] dec);
        step_dn = (idx > {3'h0, dec}) ? idx - {3'h0, dec} : 7'h0;
    endfunction

    function automatic logic [6:0] cap_of(input logic [6:0] v,
                                          input logic [6:0] cap);
        cap_of = (v > cap) ? cap : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [7:0] step_cfg_q;
    logic [7:0] dec_cfg_q;

    wire wr_step = reg_wr && (reg_addr == `OFS_STEP_CFG);
    wire wr_dec  = reg_wr && (reg_addr == `OFS_DEC_STEP_CFG);

    always_ff @(posedge clk) begin
        if (rst) begin
            step_cfg_q <= `RST_STEP_CFG;
            dec_cfg_q  <= `RST_DEC_STEP_CFG;
        end else begin
            if (wr_step) step_cfg_q <= reg_wdata;
            if (wr_dec)  dec_cfg_q  <= reg_wdata;
        end
    end

    wire steer   = step_cfg_q[`FLD_STEER_BIT];
    wire pin_tgt = step_cfg_q[`FLD_PIN_TGT_BIT];
    // Stored step field plus one, so no step is ever zero
    wire [3:0] inc_step  = {1'b0, step_cfg_q[`FLD_INC_STEP_LO +: 3]}
                           + 4'h1;
    wire [3:0] fe_dec    = {1'b0, dec_cfg_q[`FLD_FE_DEC_LO +: 3]}
                           + 4'h1;
    wire [3:0] filt_dec  = {1'b0, dec_cfg_q[`FLD_FILT_DEC_LO +: 3]}
                           + 4'h1;

    // Caps shared by both receivers
    wire [6:0] full_tab  = digital_gain_en ? `FULL_DIG_MAX
                                           : `FULL_ANALOG_MAX;
    wire [6:0] full_cap  = cap_of(max_gain_index_limit, full_tab);
    wire [6:0] split_cap = cap_of(max_gain_index_limit,
                                  `SPLIT_FE_MAX);
    wire [6:0] fe_cap    = split_mode ? split_cap : full_cap;
    wire [4:0] dig_cap   = digital_gain_en ? `DIG_IDX_MAX : 5'h00;

    ////////////////////////////////////////////////////////////////////////
    // Pin step events

    logic [3:0] pin_step;
    wire  [3:0] pins = {rx2_gain_down_pin, rx2_gain_up_pin,
                        rx1_gain_down_pin, rx1_gain_up_pin};

    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_pin
            pin_step_detect #(
                .MIN_CYC (`PIN_MIN_CYCLES)
            ) u_det (
                .clk  (clk),
                .rst  (rst),
                .pin  (pins[p]),
                .step (pin_step[p])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Index pointers per receiver

    rx_gain_pkg::gain_idx_t   idx_q [2];
    rx_gain_pkg::ovl_flags_t  flg [2];
    rx_gain_pkg::target_t     tgt [2];
    logic [1:0]               up_ev;
    logic [1:0]               dn_ev;

    assign flg[0] = rx1_flags;
    assign flg[1] = rx2_flags;

    genvar r;
    generate
        for (r = 0; r < 2; r++) begin : g_rx
            wire [9:0] base   = `OFS_RX1_FE_IDX
                                + (r == 0 ? 10'h000 : `RX_IDX_STRIDE);
            wire       wr_fe  = reg_wr && (reg_addr == base);
            wire       wr_fl  = reg_wr && (reg_addr == base + 10'h001);
            wire       wr_dg  = reg_wr && (reg_addr == base + 10'h002);
            wire       up_raw = pin_control_en && pin_step[2*r];
            wire       dn_raw = pin_control_en && pin_step[2*r+1];
            wire       wr_any = wr_fe || wr_fl || wr_dg;

            // Opposite steps together cancel; register writes win
            assign up_ev[r] = up_raw && !dn_raw && !wr_any;
            assign dn_ev[r] = dn_raw && !up_raw && !wr_any;

            wire [6:0] fe   = idx_q[r].fe;
            wire       fe_upper = fe > initial_fe_limit;
            rx_gain_pkg::target_t dn_tgt;
            rx_gain_pkg::target_t up_tgt;

            // Overload priority and table position pick the table
            assign dn_tgt =
                flg[r].fe_large ? ((fe != 7'h0) ? rx_gain_pkg::TGT_FE
                                : rx_gain_pkg::TGT_FILT) :
                flg[r].adc_ovl  ? (fe_upper ? rx_gain_pkg::TGT_FE
                                : rx_gain_pkg::TGT_FILT) :
                flg[r].dig_sat  ? rx_gain_pkg::TGT_DIG :
                (fe != 7'h0)    ? rx_gain_pkg::TGT_FE
                                : rx_gain_pkg::TGT_FILT;
            assign up_tgt = (idx_q[r].filt < `FILT_IDX_MAX)
                            ? rx_gain_pkg::TGT_FILT
                            : rx_gain_pkg::TGT_FE;
            assign tgt[r] =
                !split_mode ? rx_gain_pkg::TGT_FE :
                steer       ? (dn_ev[r] ? dn_tgt : up_tgt) :
                pin_tgt     ? rx_gain_pkg::TGT_FE
                            : rx_gain_pkg::TGT_FILT;

            wire [6:0] fe_up   = step_up(fe, inc_step, fe_cap);
            wire [6:0] fe_dn   = step_dn(fe, fe_dec);
            wire [6:0] fl_up   = step_up({2'h0, idx_q[r].filt}, inc_step,
                                         {2'h0, `FILT_IDX_MAX});
            wire [6:0] fl_dn   = step_dn({2'h0, idx_q[r].filt}, filt_dec);
            wire [6:0] dg_up   = step_up({2'h0, idx_q[r].dig}, 4'h1,
                                         {2'h0, dig_cap});
            wire [6:0] dg_dn   = step_dn({2'h0, idx_q[r].dig}, 4'h1);
            wire [6:0] wr_fe_v = cap_of(reg_wdata[6:0], fe_cap);
            wire [6:0] wr_fl_v = cap_of(reg_wdata[6:0],
                                        {2'h0, `FILT_IDX_MAX});
            wire [6:0] wr_dg_v = cap_of(reg_wdata[6:0], {2'h0, dig_cap});
            wire       mv_fe   = tgt[r] == rx_gain_pkg::TGT_FE;
            wire       mv_fl   = tgt[r] == rx_gain_pkg::TGT_FILT;
            wire       mv_dg   = tgt[r] == rx_gain_pkg::TGT_DIG;

            wire [6:0] fe_d =
                wr_fe              ? wr_fe_v :
                (up_ev[r] && mv_fe) ? fe_up :
                (dn_ev[r] && mv_fe) ? cap_of(fe_dn, fe_cap) :
                cap_of(fe, fe_cap);
            wire [6:0] fl_d =
                wr_fl && split_mode ? wr_fl_v :
                (up_ev[r] && mv_fl) ? fl_up :
                (dn_ev[r] && mv_fl) ? fl_dn :
                {2'h0, idx_q[r].filt};
            wire [6:0] dg_d =
                wr_dg               ? wr_dg_v :
                (up_ev[r] && mv_dg) ? dg_up :
                (dn_ev[r] && mv_dg) ? cap_of(dg_dn, {2'h0, dig_cap}) :
                cap_of({2'h0, idx_q[r].dig}, {2'h0, dig_cap});

            always_ff @(posedge clk) begin
                if (rst) begin
                    idx_q[r] <= '0;
                end else begin
                    idx_q[r].fe   <= fe_d;
                    idx_q[r].filt <= fl_d[4:0];
                    idx_q[r].dig  <= dg_d[4:0];
                end
            end
        end
    endgenerate

    assign rx1_index = idx_q[0];
    assign rx2_index = idx_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Control outputs and readback

    logic [7:0] ctrl_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;

    always_comb begin
        case (reg_addr)
            `OFS_STEP_CFG:     rd_mux = step_cfg_q;
            `OFS_DEC_STEP_CFG: rd_mux = dec_cfg_q;
            `OFS_RX1_FE_IDX:   rd_mux = {1'b0, idx_q[0].fe};
            `OFS_RX1_FILT_IDX: rd_mux = {3'h0, idx_q[0].filt};
            `OFS_RX1_DIG_IDX:  rd_mux = {3'h0, idx_q[0].dig};
            `OFS_RX2_FE_IDX:   rd_mux = {1'b0, idx_q[1].fe};
            `OFS_RX2_FILT_IDX: rd_mux = {3'h0, idx_q[1].filt};
            `OFS_RX2_DIG_IDX:  rd_mux = {3'h0, idx_q[1].dig};
            default:           rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q  <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            ctrl_q  <= ctrl_out_en ? {rx2_flags, rx1_flags} : 8'h00;
            rdata_q <= rd_mux;
        end
    end

    assign ctrl_out  = ctrl_q;
    assign reg_rdata = rdata_q;

    power_averager #(
        .PW (PW)
    ) u_pwr (
        .clk        (clk),
        .rst        (rst),
        .samp_valid (samp_valid),
        .samp_power (samp_power),
        .duration   (power_meas_duration),
        .avg_power  (avg_power),
        .avg_valid  (avg_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire quiet0 = !reg_wr && !pin_step[0] && !pin_step[1];

    fe_cap_a: assert property (!$past(rst) |->
        idx_q[0].fe <= $past(fe_cap))
        else $error("front-end index above limit");

    split_max_a: assert property (split_mode && $past(split_mode) |->
        idx_q[1].filt <= `FILT_IDX_MAX && idx_q[1].dig <= `DIG_IDX_MAX
        && idx_q[1].fe <= `SPLIT_FE_MAX)
        else $error("split index above maximum");

    full_step_a: assert property (!split_mode && up_ev[0]
        && {1'b0, idx_q[0].fe} + {4'h0, inc_step} <= {1'b0, fe_cap}
        |=> idx_q[0].fe == $past(idx_q[0].fe) + 7'($past(inc_step)))
        else $error("full index pin step wrong");

    write_set_a: assert property (reg_wr
        && reg_addr == `OFS_RX1_FE_IDX && reg_wdata[6:0] <= fe_cap
        |=> idx_q[0].fe == $past(reg_wdata[6:0]))
        else $error("index write not applied");

    dig_pin_a: assert property (split_mode && !steer
        && !reg_wr |=> $stable(idx_q[0].dig) && $stable(idx_q[1].dig))
        else $error("pin moved digital index");

    pin_target_a: assert property (split_mode && !steer
        && !pin_tgt && (up_ev[0] || dn_ev[0])
        |=> $stable(idx_q[0].fe))
        else $error("filter target moved front-end");

    steer_fe_a: assert property (split_mode && steer && dn_ev[0]
        && rx1_flags.fe_large && idx_q[0].fe != 7'h0
        |=> idx_q[0].fe < $past(idx_q[0].fe) && $stable(idx_q[0].filt))
        else $error("large overload did not cut front-end");

    prio_a: assert property (split_mode && steer && dn_ev[0]
        && rx1_flags.fe_large && rx1_flags.dig_sat
        |=> $stable(idx_q[0].dig))
        else $error("saturation beat front-end overload");

    rx_alone_a: assert property (quiet0 ##0 !pin_step[2]
        && !pin_step[3] |=> $stable(idx_q[1].filt))
        else $error("receiver 2 moved without cause");

    ctrl_route_a: assert property (ctrl_out_en
        |=> ctrl_out == {$past(rx2_flags), $past(rx1_flags)})
        else $error("control outputs not routed");

endmodule

`default_nettype wire

// ==== hw/rx_gain_cfg.svh ====
// Constants for the receive gain index pointer logic.
// Assumes inclusion by bare name from the design modules.
`ifndef RX_GAIN_CFG_SVH
`define RX_GAIN_CFG_SVH

// Register offsets, byte addressed on the 10-bit register port
`define OFS_STEP_CFG      10'h0FC
`define OFS_DEC_STEP_CFG  10'h0FE
`define OFS_RX1_FE_IDX    10'h2B0
`define OFS_RX1_FILT_IDX  10'h2B1
`define OFS_RX1_DIG_IDX   10'h2B2
`define OFS_RX2_FE_IDX    10'h2B5
`define OFS_RX2_FILT_IDX  10'h2B6
`define OFS_RX2_DIG_IDX   10'h2B7
`define RX_IDX_STRIDE     10'h005

// Fields of the step configuration register
`define FLD_INC_STEP_LO   0
`define FLD_STEER_BIT     3
`define FLD_PIN_TGT_BIT   4
// Fields of the decrement step register
`define FLD_FE_DEC_LO     0
`define FLD_FILT_DEC_LO   4
`define STEP_FLD_W        3

// Reset values
`define RST_STEP_CFG      8'h00
`define RST_DEC_STEP_CFG  8'h00

// Index limits
`define SPLIT_FE_MAX      7'h28
`define FILT_IDX_MAX      5'h18
`define DIG_IDX_MAX       5'h1F
`define FULL_DIG_MAX      7'h5A
`define FULL_ANALOG_MAX   7'h4C

// Timing
`define PIN_MIN_CYCLES    2
`define PWR_BASE_SAMPLES  16

`endif

// ==== hw/rx_gain_pkg.sv ====
// Types shared by the receive gain index pointer logic.
// Assumes nothing beyond a SystemVerilog compiler.
package rx_gain_pkg;

    // Gain change destination, one-hot
    typedef enum logic [2:0] {
        TGT_NONE = 3'h0,
        TGT_FE   = 3'h1,
        TGT_FILT = 3'h2,
        TGT_DIG  = 3'h4
    } target_t;

    // Detector flags of one receiver
    typedef struct packed {
        logic dig_sat;
        logic adc_ovl;
        logic fe_small;
        logic fe_large;
    } ovl_flags_t;

    // Index pointers of one receiver; fe holds the full index in full mode
    typedef struct packed {
        logic [6:0] fe;
        logic [4:0] filt;
        logic [4:0] dig;
    } gain_idx_t;

endpackage

// ==== hw/pin_step_detect.sv ====
// Synchroniser and pulse qualifier for one asynchronous gain step pin.
// Assumes the pin is driven from outside the clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "rx_gain_cfg.svh"

module pin_step_detect #(
    parameter int MIN_CYC = `PIN_MIN_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      step
);

    initial begin
        if (MIN_CYC < 1 || MIN_CYC > 15) begin
            $error("pin_step_detect: MIN_CYC out of range");
        end
    end

    logic       s1_q;
    logic       s2_q;
    logic       stable_q;
    logic       pulse_q;
    logic [3:0] cnt_q;
    wire        differ  = s2_q != stable_q;
    wire        accept  = differ && (cnt_q == 4'(MIN_CYC - 1));

    always_ff @(posedge clk) begin
        s1_q <= pin;
        s2_q <= s1_q;
    end

    // Level must persist before it is taken as a new pin state
    always_ff @(posedge clk) begin
        if (rst) begin
            stable_q <= 1'b0;
            cnt_q    <= 4'h0;
            pulse_q  <= 1'b0;
        end else begin
            cnt_q    <= (differ && !accept) ? cnt_q + 4'h1 : 4'h0;
            stable_q <= accept ? s2_q : stable_q;
            pulse_q  <= accept && s2_q;
        end
    end

    assign step = pulse_q;

    sequence rise_held_s;
        (!s2_q && !stable_q) ##1 (s2_q && !stable_q) [*2];
    endsequence

    pulse_seen_a: assert property (@(posedge clk) disable iff (rst)
        rise_held_s |=> pulse_q)
        else $error("held pulse not detected");

    pulse_single_a: assert property (@(posedge clk) disable iff (rst)
        pulse_q |=> !pulse_q)
        else $error("one pin pulse gave two steps");

endmodule

`default_nettype wire

// ==== hw/power_averager.sv ====
// Average of sample power over 16 times two to the duration field latched at the end of the previous window; reset loads zero.
// Assumes samp_valid comes from logic on clk.
`timescale 1ns/1ps
`default_nettype none
`include "rx_gain_cfg.svh"

module power_averager #(
    parameter int PW = 16
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          samp_valid,
    input  wire logic [PW-1:0] samp_power,
    input  wire logic [3:0]    duration,
    output logic [PW-1:0]      avg_power,
    output logic               avg_valid
);

    initial begin
        if (PW < 1 || PW > 32) begin
            $error("power_averager: PW out of range");
        end
    end

    localparam int AW = PW + 19;

    logic [AW-1:0] acc_q;
    logic [18:0]   cnt_q;
    logic [3:0]    dur_q;
    logic [PW-1:0] avg_q;
    logic          valid_q;
    wire  [18:0]   last = (19'(`PWR_BASE_SAMPLES) << dur_q) - 19'h1;
    wire  [AW-1:0] sum  = acc_q + AW'(samp_power);
    wire           done = samp_valid && (cnt_q == last);
    wire  [AW-1:0] mean = sum >> ({1'b0, dur_q} + 5'h04);

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q   <= '0;
            cnt_q   <= 19'h0;
            dur_q   <= 4'h0;
            avg_q   <= '0;
            valid_q <= 1'b0;
        end else begin
            valid_q <= done;
            if (samp_valid) begin
                acc_q <= done ? '0 : sum;
                cnt_q <= done ? 19'h0 : cnt_q + 19'h1;
            end
            if (done) begin
                avg_q <= mean[PW-1:0];
                dur_q <= duration;
            end
        end
    end

    assign avg_power = avg_q;
    assign avg_valid = valid_q;

    window_len_a: assert property (@(posedge clk) disable iff (rst)
        valid_q |-> $past(cnt_q) == (19'(`PWR_BASE_SAMPLES) << $past(dur_q))
                    - 19'h1)
        else $error("power window length wrong");

endmodule

`default_nettype wire

// ==== bench/host_model.sv ====
// Baseband host model: register writes and gain step pin pulses.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input  wire logic       clk,
    output logic      [9:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic      [3:0] pins
);
    initial begin
        reg_addr  = 10'h000;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        pins      = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // One write strobe per call; stale data scrambled afterwards
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk) #1;
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask

    // Point the read port and let the registered data land
    task automatic sel(input logic [9:0] a);
        @(posedge clk) #1;
        reg_addr = a;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // High 3 cycles, low 6, so the step has landed on return
    task automatic pulse(input int n);
        @(posedge clk) #1;
        pins[n] = 1'b1;
        repeat (3) @(posedge clk);
        #1 pins[n] = 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule

`default_nettype wire

// ==== bench/rx_gain_index_control_tb.sv ====
// Self-checking bench for the receive gain index pointers.
// Assumes host_model drives the register port and the step pins.
`timescale 1ns/1ps
`default_nettype none

module rx_gain_index_control_tb;
    logic                     clk, rst, split, dig_en, pin_en, cout_en;
    logic                     reg_wr, sv, avg_valid;
    logic [6:0]               limit, fe_lim;
    logic [3:0]               pins, dur;
    logic [9:0]               addr;
    logic [7:0]               wdata, rdata, ctrl_out;
    logic [15:0]              spow, avg;
    rx_gain_pkg::ovl_flags_t  f1, f2;
    rx_gain_pkg::gain_idx_t   i1, i2;
    int                       n_fail, samples_checked, cyc;
    typedef struct packed {
        logic [9:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    row_t rows [7] = '{
        '{10'h2B0, 8'h30, 8'h28},
        '{10'h2B1, 8'h1F, 8'h18},
        '{10'h2B2, 8'h1F, 8'h1F},
        '{10'h2B6, 8'h03, 8'h03},
        '{10'h0FE, 8'h13, 8'h13},
        '{10'h0FC, 8'h10, 8'h10},
        '{10'h100, 8'h55, 8'h00}};

    host_model host (.clk(clk), .reg_addr(addr), .reg_wr(reg_wr),
                     .reg_wdata(wdata), .pins(pins));
    rx_gain_index_control dut (
        .clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(reg_wr),
        .reg_wdata(wdata), .reg_rdata(rdata), .split_mode(split),
        .digital_gain_en(dig_en), .pin_control_en(pin_en),
        .max_gain_index_limit(limit), .initial_fe_limit(fe_lim),
        .rx1_gain_up_pin(pins[0]), .rx1_gain_down_pin(pins[1]),
        .rx2_gain_up_pin(pins[2]), .rx2_gain_down_pin(pins[3]),
        .rx1_flags(f1), .rx2_flags(f2), .ctrl_out_en(cout_en),
        .ctrl_out(ctrl_out), .rx1_index(i1), .rx2_index(i2),
        .power_meas_duration(dur), .samp_valid(sv), .samp_power(spow),
        .avg_power(avg), .avg_valid(avg_valid));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1; split = 1'b1; dig_en = 1'b1; pin_en = 1'b1;
        cout_en = 1'b0; sv = 1'b0; spow = 16'h0000; dur = 4'h1;
        limit = 7'h7F; fe_lim = 7'h0A; f1 = '0; f2 = '0;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        check(i1, 17'h00000);
        foreach (rows[k]) begin
            host.wr(rows[k].a, rows[k].d);
            host.sel(rows[k].a);
            check(rdata, rows[k].e);
        end
        // Split pins, front-end target
        host.wr(10'h2B0, 8'h05);
        host.pulse(0);
        check(i1.fe, 7'h06);
        host.pulse(1);
        check(i1.fe, 7'h02);
        host.pulse(1);
        check(i1.fe, 7'h00);
        // Split pins, filter target
        host.wr(10'h0FC, 8'h00);
        host.pulse(0);
        check(i1.filt, 5'h18);
        host.pulse(1);
        check(i1.filt, 5'h16);
        check(i1.dig, 5'h1F);
        host.pulse(2);
        check(i2.filt, 5'h04);
        // Detector steering
        host.wr(10'h0FC, 8'h08);
        host.wr(10'h2B0, 8'h14);
        f1 = 4'h9;
        host.pulse(1);
        check(i1.fe, 7'h10);
        f1 = 4'h4;
        host.pulse(1);
        check(i1.fe, 7'h0C);
        host.wr(10'h2B0, 8'h08);
        host.pulse(1);
        check(i1.filt, 5'h14);
        fe_lim = 7'h05;
        host.pulse(1);
        check(i1.fe, 7'h04);
        f2 = 4'h4;
        host.pulse(3);
        check(i2.filt, 5'h02);
        f1 = 4'h8;
        host.pulse(1);
        check(i1.dig, 5'h1E);
        f1 = 4'h0;
        host.pulse(0);
        check(i1.filt, 5'h15);
        // Flags out
        cout_en = 1'b1;
        f1 = 4'h8;
        f2 = 4'h2;
        repeat (2) @(posedge clk);
        #1 check(ctrl_out, 8'h28);
        // Full table mode
        f1 = 4'h0;
        split = 1'b0;
        dig_en = 1'b0;
        host.wr(10'h0FC, 8'h00);
        host.wr(10'h2B0, 8'h7F);
        check(i1.fe, 7'h4C);
        dig_en = 1'b1;
        host.wr(10'h2B0, 8'h7F);
        check(i1.fe, 7'h5A);
        limit = 7'h30;
        host.sel(10'h2B0);
        check(i1.fe, 7'h30);
        host.pulse(0);
        check(i1.fe, 7'h30);
        host.pulse(1);
        check(i1.fe, 7'h2C);
        host.pulse(0);
        check(i1.fe, 7'h2D);
        pin_en = 1'b0;
        host.pulse(1);
        check(i1.fe, 7'h2D);
        // Mid-run reset clears pointers and outputs
        @(posedge clk) #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        check(i1, 17'h00000);
        check(i2, 17'h00000);
        check(ctrl_out, 8'h00);
        check(rdata, 8'h00);
        // First window 16 samples, then 16 << latched duration
        for (int w = 0; w < 2; w++) begin
            for (int k = 0; k < (16 << w); k++) begin
                @(posedge clk) #1;
                sv = 1'b1;
                spow = 16'(k) << 11;
                dur = 4'(1 - w);
            end
            @(posedge clk) #1;
            sv = 1'b0;
            check(avg_valid, 1'b1);
            check(avg, w ? 16'h7C00 : 16'h3C00);
        end
        results();
    end
endmodule

`default_nettype wire
